/* ttfs_frame_scheduler.sv */
// Frame scheduler for a time-triggered bus port: APB register file, transmit
// slot handling with data/null choice, receive filtering and PDU update bits.
// Assumes the protocol engine on the same clock gives slot and cycle pulses
// and one-cycle receive strobes.
//
// Contract
// - Single or queued input drops received null frames.
// - Stream input delivers every received data frame.
// - Stream input passes null frames only with null-to-stream set.
// - Each delivered frame carries a data or null type flag.
// - Cyclic frames transmit every opportunity, repeating old payload.
// - Cyclic static frames always send data; host null writes dropped.
// - Cyclic dynamic frames send data every cycle.
// - Frame output stream mode is refused.
// - Static opportunities spaced by cycle repetition; in-cycle repeats optional.
// - Event static frame without fresh write sends a null frame.
// - Event dynamic frame sends only with new data pending.
// - Event data sent once per host write.
// - Frame holds several non-overlapping PDUs, each handled alone.
// - A PDU sits at a start bit with a byte length.
// - Received PDU with update bit accepted only when bit set.
// - Transmit update bit set when PDU has fresh data.
// - Cyclic PDU frames still sent with update bits cleared.
// - Event PDU frames sent only when some PDU is fresh.
// - PDU handling only on the time-triggered bus type.
// - Static uses null frames for no data; dynamic omits the frame.
`timescale 1ns/100ps
module ttfs_frame_scheduler (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus timing from protocol engine
	input wire logic cycle_start,
	input wire logic slot,
	// Receive side
	input wire logic rx_valid,
	input wire logic rx_null,
	input wire logic [63:0] rx_payload,
	// Transmit side
	output logic tx_valid,
	output logic tx_null,
	output logic [63:0] tx_payload
);
	typedef struct packed {
		logic [31:0] ctrl_q;
		logic [63:0] stage_q;
		logic [63:0] payload_q;
		logic pending_q;
		logic [1:0] pdu_fresh_q;
		logic [63:0] rx_data_q;
		logic rx_avail_q;
		logic rx_null_q;
		logic [1:0] pdu_new_q;
		ttfs_pkg::ttfs_pdu_type [1:0] pdu_q;
		logic tx_valid_q;
		logic tx_null_q;
		logic [63:0] tx_frame_q;
		logic [31:0] prdata_q;
		logic pready_q;
		logic pslverr_q;
	} ttfs_state_type;

	ttfs_state_type s_q;
	ttfs_state_type s_d;
	ttfs_slot_if sif ();

	// Field mask of one PDU inside the frame
	function automatic logic [63:0] pdu_mask(input ttfs_pkg::ttfs_pdu_type p);
		logic [6:0] nbits;
		nbits = {p.len[3:0], 3'h0};
		return ((64'h1 << nbits) - 64'h1) << p.start;
	endfunction

	// Address decode shared by read and write paths
	function automatic logic addr_ok(input logic [7:0] a);
		return (a <= ttfs_pkg::OFS_PDU_CFG1) && (a[1:0] == 2'h0);
	endfunction

	// Register word to PDU descriptor, shared by both PDU slots
	function automatic ttfs_pkg::ttfs_pdu_type pdu_unpack(input logic [31:0] w);
		ttfs_pkg::ttfs_pdu_type p;
		p.start = w[ttfs_pkg::PDU_START +: 6];
		p.len = w[ttfs_pkg::PDU_LEN +: 4];
		p.upd_pos = w[ttfs_pkg::PDU_UPD_POS +: 6];
		p.upd_en = w[ttfs_pkg::PDU_UPD_EN];
		return p;
	endfunction

	// PDU descriptor back to its register layout; unused bits read 0
	function automatic logic [31:0] pdu_pack(input ttfs_pkg::ttfs_pdu_type p);
		logic [31:0] w;
		w = 32'h0;
		w[ttfs_pkg::PDU_START +: 6] = p.start;
		w[ttfs_pkg::PDU_LEN +: 4] = p.len;
		w[ttfs_pkg::PDU_UPD_POS +: 6] = p.upd_pos;
		w[ttfs_pkg::PDU_UPD_EN] = p.upd_en;
		return w;
	endfunction

	ttfs_pkg::ttfs_mode_type rx_mode;
	ttfs_pkg::ttfs_mode_type tx_mode;
	logic pdu_active;
	logic tx_refused;
	logic cfg_err;
	logic bus_wr;
	logic host_frame_write;
	logic host_frame_read;
	logic rx_accept;
	logic pend_eff;
	logic [63:0] keep_mask;
	logic [31:0] status;

	assign rx_mode = ttfs_pkg::ttfs_mode_type'(s_q.ctrl_q[ttfs_pkg::CTRL_RX_MODE +: 2]);
	assign tx_mode = ttfs_pkg::ttfs_mode_type'(s_q.ctrl_q[ttfs_pkg::CTRL_TX_MODE +: 2]);
	assign pdu_active = s_q.ctrl_q[ttfs_pkg::CTRL_PDU_EN] && s_q.ctrl_q[ttfs_pkg::CTRL_BUS_TT];
	assign tx_refused = (tx_mode == ttfs_pkg::MODE_STREAM) || (s_q.ctrl_q[ttfs_pkg::CTRL_TX_MODE +: 2] == 2'h3);
	assign cfg_err = tx_refused || (s_q.ctrl_q[ttfs_pkg::CTRL_PDU_EN] && !s_q.ctrl_q[ttfs_pkg::CTRL_BUS_TT]);
	// PDU frames count as fresh when any PDU is fresh
	assign pend_eff = pdu_active ? (|s_q.pdu_fresh_q) : s_q.pending_q;

	// Slot unit inputs
	assign sif.started = s_q.ctrl_q[ttfs_pkg::CTRL_START] && !tx_refused;
	assign sif.event_timed = s_q.ctrl_q[ttfs_pkg::CTRL_EVENT];
	assign sif.dynamic = s_q.ctrl_q[ttfs_pkg::CTRL_DYNAMIC];
	assign sif.in_cyc_en = s_q.ctrl_q[ttfs_pkg::CTRL_IN_CYC];
	assign sif.cyc_rep = s_q.ctrl_q[ttfs_pkg::CTRL_CYC_REP +: 8];
	assign sif.cycle_start = cycle_start;
	assign sif.slot = slot;
	assign sif.pending = pend_eff;

	ttfs_slot_decider u_decider (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.sif(sif)
	);

	// Write takes effect only at the edge that completes the access
	assign bus_wr = psel && penable && pwrite && s_q.pready_q && !s_q.pslverr_q;
	assign host_frame_write = bus_wr && (paddr == ttfs_pkg::OFS_TX_WRITE);
	assign host_frame_read = bus_wr && (paddr == ttfs_pkg::OFS_RX_ACK);

	// Receive acceptance per input mode
	always_comb begin
		rx_accept = 1'b0;
		if (rx_valid) begin
			if (rx_mode == ttfs_pkg::MODE_STREAM) begin
				rx_accept = !rx_null || s_q.ctrl_q[ttfs_pkg::CTRL_NULL_TO_STREAM];
			end else begin
				rx_accept = !rx_null;
			end
		end
	end

	// PDUs without a set update bit keep their old contents
	always_comb begin
		keep_mask = 64'h0;
		for (int i = 0; i < ttfs_pkg::NUM_PDU; i++) begin
			if (pdu_active && s_q.pdu_q[i].upd_en && !rx_payload[s_q.pdu_q[i].upd_pos] && !rx_null) begin
				keep_mask = keep_mask | pdu_mask(s_q.pdu_q[i]);
			end
		end
	end

	// Status word shows live block state
	always_comb begin
		status = 32'h0;
		status[ttfs_pkg::STAT_CFG_ERR] = cfg_err;
		status[ttfs_pkg::STAT_PENDING] = pend_eff;
		status[ttfs_pkg::STAT_RX_AVAIL] = s_q.rx_avail_q;
		status[ttfs_pkg::STAT_RX_NULL] = s_q.rx_null_q;
		status[ttfs_pkg::STAT_PDU_NEW +: 2] = s_q.pdu_new_q;
		status[ttfs_pkg::STAT_PDU_FRESH +: 2] = s_q.pdu_fresh_q;
	end

	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.tx_valid_q = 1'b0;
		s_d.tx_null_q = 1'b0;

		// APB: read data and error latched in setup, pready one cycle later
		s_d.pready_q = psel && !penable;
		s_d.pslverr_q = psel && !penable && !addr_ok(paddr);
		s_d.prdata_q = 32'h0;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ttfs_pkg::OFS_CTRL: s_d.prdata_q = s_q.ctrl_q;
				ttfs_pkg::OFS_STATUS: s_d.prdata_q = status;
				ttfs_pkg::OFS_TX_DATA0: s_d.prdata_q = s_q.stage_q[31:0];
				ttfs_pkg::OFS_TX_DATA1: s_d.prdata_q = s_q.stage_q[63:32];
				ttfs_pkg::OFS_RX_DATA0: s_d.prdata_q = s_q.rx_data_q[31:0];
				ttfs_pkg::OFS_RX_DATA1: s_d.prdata_q = s_q.rx_data_q[63:32];
				ttfs_pkg::OFS_PDU_CFG0: s_d.prdata_q = pdu_pack(s_q.pdu_q[0]);
				ttfs_pkg::OFS_PDU_CFG1: s_d.prdata_q = pdu_pack(s_q.pdu_q[1]);
				default: s_d.prdata_q = 32'h0;
			endcase
		end

		// Register writes
		if (bus_wr) begin
			unique case (paddr)
				ttfs_pkg::OFS_CTRL: s_d.ctrl_q = pwdata;
				ttfs_pkg::OFS_TX_DATA0: s_d.stage_q[31:0] = pwdata;
				ttfs_pkg::OFS_TX_DATA1: s_d.stage_q[63:32] = pwdata;
				ttfs_pkg::OFS_PDU_CFG0: s_d.pdu_q[0] = pdu_unpack(pwdata);
				ttfs_pkg::OFS_PDU_CFG1: s_d.pdu_q[1] = pdu_unpack(pwdata);
				default: ;
			endcase
		end

		// Transmit slot: data, null or nothing
		if (sif.send) begin
			s_d.tx_valid_q = 1'b1;
			s_d.tx_frame_q = s_q.payload_q;
			for (int i = 0; i < ttfs_pkg::NUM_PDU; i++) begin
				if (pdu_active && s_q.pdu_q[i].upd_en) begin
					s_d.tx_frame_q[s_q.pdu_q[i].upd_pos] = s_q.pdu_fresh_q[i];
				end
			end
			s_d.pending_q = 1'b0;
			s_d.pdu_fresh_q = 2'h0;
		end else if (sif.send_null) begin
			s_d.tx_valid_q = 1'b1;
			s_d.tx_null_q = 1'b1;
			s_d.tx_frame_q = 64'h0;
		end

		// Host write after the send decision so a racing write is kept
		if (host_frame_write && !pwdata[ttfs_pkg::CMD_NULL]) begin
			s_d.payload_q = s_q.stage_q;
			s_d.pending_q = 1'b1;
			s_d.pdu_fresh_q = s_d.pdu_fresh_q | (pwdata[ttfs_pkg::CMD_PDU +: 2] & {2{pdu_active}});
		end

		// Receive delivery; set beats a host clear in the same cycle
		if (host_frame_read) begin
			s_d.rx_avail_q = s_q.rx_avail_q & ~pwdata[0];
			s_d.pdu_new_q = s_q.pdu_new_q & ~pwdata[ttfs_pkg::STAT_PDU_NEW +: 2];
		end
		if (rx_accept) begin
			s_d.rx_data_q = (rx_payload & ~keep_mask) | (s_q.rx_data_q & keep_mask);
			s_d.rx_avail_q = 1'b1;
			s_d.rx_null_q = rx_null;
			for (int i = 0; i < ttfs_pkg::NUM_PDU; i++) begin
				if (pdu_active && s_q.pdu_q[i].upd_en && !rx_null && rx_payload[s_q.pdu_q[i].upd_pos]) begin
					s_d.pdu_new_q[i] = 1'b1;
				end
			end
		end
	end

	// State register; enable low freezes everything
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.ctrl_q <= ttfs_pkg::CTRL_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = s_q.prdata_q;
	assign pready = s_q.pready_q;
	assign pslverr = s_q.pslverr_q;
	assign tx_valid = s_q.tx_valid_q;
	assign tx_null = s_q.tx_null_q;
	assign tx_payload = s_q.tx_frame_q;

	a_null_rx_drop: assert property (@(posedge clock) disable iff (!rstn)
		(ce && rx_valid && rx_null && rx_mode != ttfs_pkg::MODE_STREAM) |=> (s_q.rx_data_q == $past(s_q.rx_data_q)))
		else $error("null frame delivered outside stream mode");

	a_stream_data: assert property (@(posedge clock) disable iff (!rstn)
		(ce && rx_valid && !rx_null && rx_mode == ttfs_pkg::MODE_STREAM) |=> (s_q.rx_avail_q && !s_q.rx_null_q))
		else $error("stream data frame not delivered");

	a_stream_null: assert property (@(posedge clock) disable iff (!rstn)
		(ce && rx_valid && rx_null && rx_mode == ttfs_pkg::MODE_STREAM)
		|=> (s_q.rx_null_q == $past(s_q.ctrl_q[ttfs_pkg::CTRL_NULL_TO_STREAM]) || $past(s_q.rx_null_q)))
		else $error("stream null handling wrong");

	a_null_type: assert property (@(posedge clock) disable iff (!rstn)
		(ce && rx_accept) |=> (s_q.rx_null_q == $past(rx_null)))
		else $error("type flag does not match frame");

	a_cyclic_send: assert property (@(posedge clock) disable iff (!rstn)
		(ce && sif.opportunity && !sif.event_timed) |=> (tx_valid && !tx_null))
		else $error("cyclic opportunity without data frame");

	a_stream_refused: assert property (@(posedge clock) disable iff (!rstn)
		(ce && tx_refused) |=> !tx_valid)
		else $error("transmit while output stream selected");

	a_event_null: assert property (@(posedge clock) disable iff (!rstn)
		(ce && sif.opportunity && sif.event_timed && !sif.dynamic && !pend_eff) |=> (tx_valid && tx_null))
		else $error("event static slot without null frame");

	a_event_dyn_idle: assert property (@(posedge clock) disable iff (!rstn)
		(ce && sif.opportunity && sif.event_timed && sif.dynamic && !pend_eff) |=> !tx_valid)
		else $error("event dynamic frame sent without data");

	a_send_once: assert property (@(posedge clock) disable iff (!rstn)
		(ce && sif.send && sif.event_timed && !host_frame_write) |=> !s_q.pending_q ##1 !(ce && sif.send) || pend_eff)
		else $error("event data not consumed by its send");

	a_replace_pending: assert property (@(posedge clock) disable iff (!rstn)
		(ce && host_frame_write && !pwdata[ttfs_pkg::CMD_NULL]) |=> (s_q.payload_q == $past(s_q.stage_q) && s_q.pending_q))
		else $error("host write did not replace pending payload");
endmodule

/* ttfs_pkg.sv */
// Package for the time-triggered frame scheduler: register map, field layout,
// reset values and mode encodings.
// Assumes 32-bit APB with byte addresses; every register is one aligned word.
package ttfs_pkg;
	// Data widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned FRAME_W = 64;
	localparam int unsigned NUM_PDU = 2;
	localparam int unsigned CNT_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TX_DATA0 = 8'h08;
	localparam logic [7:0] OFS_TX_DATA1 = 8'h0C;
	localparam logic [7:0] OFS_TX_WRITE = 8'h10;
	localparam logic [7:0] OFS_RX_DATA0 = 8'h14;
	localparam logic [7:0] OFS_RX_DATA1 = 8'h18;
	localparam logic [7:0] OFS_RX_ACK = 8'h1C;
	localparam logic [7:0] OFS_PDU_CFG0 = 8'h20;
	localparam logic [7:0] OFS_PDU_CFG1 = 8'h24;

	// Control register fields
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_EVENT = 1;
	localparam int unsigned CTRL_DYNAMIC = 2;
	localparam int unsigned CTRL_IN_CYC = 3;
	localparam int unsigned CTRL_RX_MODE = 4;
	localparam int unsigned CTRL_TX_MODE = 6;
	localparam int unsigned CTRL_NULL_TO_STREAM = 8;
	localparam int unsigned CTRL_PDU_EN = 9;
	localparam int unsigned CTRL_BUS_TT = 10;
	localparam int unsigned CTRL_CYC_REP = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0001_0400;

	// Status and command fields
	localparam int unsigned STAT_CFG_ERR = 0;
	localparam int unsigned STAT_PENDING = 1;
	localparam int unsigned STAT_RX_AVAIL = 2;
	localparam int unsigned STAT_RX_NULL = 3;
	localparam int unsigned STAT_PDU_NEW = 8;
	localparam int unsigned STAT_PDU_FRESH = 12;
	localparam int unsigned CMD_NULL = 0;
	localparam int unsigned CMD_PDU = 8;

	// PDU configuration fields
	localparam int unsigned PDU_START = 0;
	localparam int unsigned PDU_LEN = 8;
	localparam int unsigned PDU_UPD_POS = 16;
	localparam int unsigned PDU_UPD_EN = 24;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_QUEUED,
		MODE_STREAM
	} ttfs_mode_type;

	typedef struct packed {
		logic upd_en;
		logic [5:0] upd_pos;
		logic [3:0] len;
		logic [5:0] start;
	} ttfs_pdu_type;
endpackage

/* ttfs_slot_if.sv */
// Interface between the frame scheduler and its slot-opportunity unit.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ttfs_slot_if;
	logic started;
	logic event_timed;
	logic dynamic;
	logic in_cyc_en;
	logic [7:0] cyc_rep;
	logic cycle_start;
	logic slot;
	logic pending;
	logic opportunity;
	logic send;
	logic send_null;

	modport owner (output started, event_timed, dynamic, in_cyc_en, cyc_rep, cycle_start, slot, pending,
		input opportunity, send, send_null);
	modport decider (input started, event_timed, dynamic, in_cyc_en, cyc_rep, cycle_start, slot, pending,
		output opportunity, send, send_null);
endinterface

/* ttfs_slot_decider.sv */
// Slot-opportunity unit: spaces static transmit opportunities by cycle repetition and
// picks data, null or nothing for each opportunity.
// Assumes cycle_start and slot are single-cycle pulses on the same clock.
`timescale 1ns/100ps
module ttfs_slot_decider (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// Scheduler side
	ttfs_slot_if.decider sif
);
	typedef struct packed {
		logic [7:0] rep_cnt_q;
		logic used_q;
	} ttfs_dec_state_type;

	ttfs_dec_state_type s_q;
	ttfs_dec_state_type s_d;
	logic [7:0] rep_last;

	// Repetition zero is taken as every cycle
	assign rep_last = (sif.cyc_rep == 8'h00) ? 8'h00 : sif.cyc_rep - 8'h01;

	// Opportunity decision
	always_comb begin
		s_d = s_q;
		sif.opportunity = 1'b0;
		if (sif.started && sif.slot) begin
			if (sif.dynamic) begin
				sif.opportunity = !s_q.used_q;
			end else begin
				sif.opportunity = (s_q.rep_cnt_q == 8'h00) && (sif.in_cyc_en || !s_q.used_q);
			end
		end
		if (sif.opportunity) begin
			s_d.used_q = 1'b1;
		end
		// Cycle boundary restarts the per-cycle bookkeeping
		if (sif.cycle_start) begin
			s_d.used_q = 1'b0;
			s_d.rep_cnt_q = (s_q.rep_cnt_q >= rep_last) ? 8'h00 : s_q.rep_cnt_q + 8'h01;
		end
		if (!sif.started) begin
			s_d.rep_cnt_q = 8'h00;
			s_d.used_q = 1'b0;
		end
		// Cyclic always carries data; event sends data only when fresh
		sif.send = sif.opportunity && (!sif.event_timed || sif.pending);
		sif.send_null = sif.opportunity && sif.event_timed && !sif.dynamic && !sif.pending;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	a_one_per_cycle: assert property (@(posedge clock) disable iff (!rstn)
		(ce && sif.opportunity && !sif.in_cyc_en && !sif.cycle_start) |=> !(sif.opportunity && ce) || sif.dynamic)
		else $error("second opportunity in one cycle");
endmodule

/* ttfs_bus_node.sv */
// Bus-side model for the frame scheduler: cycle and slot timing, remote
// frames arriving, and capture of what the scheduler puts on the bus.
// Assumes the scheduler samples on the rising edge of the shared clock.
`timescale 1ns/100ps
module ttfs_bus_node (
	// Clock
	input wire logic clock,
	// Timing and received frames
	output logic cycle_start,
	output logic slot,
	output logic rx_valid,
	output logic rx_null,
	output logic [63:0] rx_payload,
	// Transmitted frames
	input wire logic tx_valid,
	input wire logic tx_null,
	input wire logic [63:0] tx_payload
);
	logic [1:0] kind;
	logic [63:0] pay;

	// Quiet bus at time zero
	initial begin
		cycle_start = 1'b0;
		slot = 1'b0;
		rx_valid = 1'b0;
		rx_null = 1'b0;
		rx_payload = 64'h0;
	end

	// Start of a communication cycle
	task automatic cyc();
		@(posedge clock);
		cycle_start <= 1'b1;
		@(posedge clock);
		cycle_start <= 1'b0;
	endtask

	// Slot pulse; the answer stands one cycle, so look mid-cycle
	task automatic slt();
		@(posedge clock);
		slot <= 1'b1;
		@(posedge clock);
		slot <= 1'b0;
		@(negedge clock);
		kind = tx_valid ? (tx_null ? 2'h2 : 2'h1) : 2'h0;
		pay = tx_payload;
	endtask

	// Remote frame; lines carry junk once the strobe drops
	task automatic rx(input logic n, input logic [63:0] d);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_null <= n;
		rx_payload <= d;
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_null <= ~n;
		rx_payload <= ~d;
	endtask
endmodule

/* testbench.sv */
// Self-checking bench for the frame scheduler: APB master, bus model,
// random payloads and corner cases.
// Assumes the scheduler answers APB after one access cycle.
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cycle_start, slot, rx_valid, rx_null, tx_valid, tx_null;
	logic [63:0] rx_payload, tx_payload;
	logic [31:0] seed = 32'hB368;
	logic [31:0] rdat;
	logic rerr;
	int error_cnt = 0;
	int check_count = 0;

	// 20 MHz clock
	always #25 clock = ~clock;

	ttfs_frame_scheduler dut_u (.clock(clock), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cycle_start(cycle_start), .slot(slot), .rx_valid(rx_valid), .rx_null(rx_null),
		.rx_payload(rx_payload), .tx_valid(tx_valid), .tx_null(tx_null), .tx_payload(tx_payload));
	ttfs_bus_node bus_u (.clock(clock), .cycle_start(cycle_start), .slot(slot), .rx_valid(rx_valid),
		.rx_null(rx_null), .rx_payload(rx_payload), .tx_valid(tx_valid), .tx_null(tx_null),
		.tx_payload(tx_payload));

	// Xorshift source, fixed seed keeps runs repeatable
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected slot outcome: 0 nothing, 1 data, 2 null
	function automatic logic [1:0] exp_kind(logic ev, logic dyn, logic fresh);
		return (!ev || fresh) ? 2'h1 : (dyn ? 2'h0 : 2'h2);
	endfunction

	// Control word, started, repetition 1
	function automatic logic [31:0] ctl(logic ev, logic dyn, logic inc, logic [1:0] rxm, logic [1:0] txm,
		logic n2s, logic pdu, logic tt);
		return {8'h00, 8'h01, 5'h00, tt, pdu, n2s, txm, rxm, inc, dyn, ev, 1'b1};
	endfunction

	task automatic chk(logic [63:0] v, logic [63:0] e);
		check_count++;
		if (v !== e) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One APB transfer; wait for pready is bounded
	task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			finish_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		ap(1'b1, a, d);
	endtask

	task automatic rd(logic [7:0] a);
		ap(1'b0, a, rnd());
	endtask

	// Stop first so the repetition count restarts
	task automatic cfg(logic [31:0] v);
		wr(ttfs_pkg::OFS_CTRL, 32'h0);
		wr(ttfs_pkg::OFS_CTRL, v);
	endtask

	task automatic send(logic [63:0] p, logic [31:0] w);
		wr(ttfs_pkg::OFS_TX_DATA0, p[31:0]);
		wr(ttfs_pkg::OFS_TX_DATA1, p[63:32]);
		wr(ttfs_pkg::OFS_TX_WRITE, w);
	endtask

	// Slot, then compare kind and, for data, payload
	task automatic tx(logic [1:0] k, logic [63:0] p);
		bus_u.slt();
		chk(bus_u.kind, k);
		if (k == 2'h1) begin
			chk(bus_u.pay, p);
		end
	endtask

	// Main sequence
	initial begin
		logic [63:0] p, q, lp;
		logic ev, dyn, f;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rd(ttfs_pkg::OFS_CTRL);
		chk(rdat, ttfs_pkg::CTRL_RESET);
		rd(8'h40);
		chk({rdat, rerr}, 33'h1);
		wr(ttfs_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rd(ttfs_pkg::OFS_STATUS);
		chk(rdat, 32'h0);
		$display("registers done");
		for (int m = 2; m < 4; m++) begin
			cfg(ctl(1'b0, 1'b0, 1'b0, 2'h0, m[1:0], 1'b0, 1'b0, 1'b1));
			bus_u.cyc();
			tx(2'h0, 64'h0);
			rd(ttfs_pkg::OFS_STATUS);
			chk(rdat[0], 1'b1);
		end
		$display("stream output refusal done");
		cfg(ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
		p = {rnd(), rnd()};
		send(p, 32'h0);
		lp = {rnd(), rnd()};
		send(lp, 32'h0);
		bus_u.cyc();
		tx(2'h1, lp);
		tx(2'h0, 64'h0);
		bus_u.cyc();
		tx(2'h1, lp);
		wr(ttfs_pkg::OFS_TX_DATA0, ~lp[31:0]);
		wr(ttfs_pkg::OFS_TX_WRITE, 32'h1);
		bus_u.cyc();
		tx(2'h1, lp);
		wr(ttfs_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
		bus_u.cyc();
		tx(2'h1, lp);
		tx(2'h1, lp);
		$display("cyclic static done");
		// Random mix of timing, segment and fresh writes
		for (int i = 0; i < 16; i++) begin
			ev = 1'(rnd());
			dyn = 1'(rnd());
			f = 1'(rnd());
			cfg(ctl(ev, dyn, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
			if (f) begin
				lp = {rnd(), rnd()};
				send(lp, 32'h0);
			end
			bus_u.cyc();
			tx(exp_kind(ev, dyn, f), lp);
		end
		$display("random timing done");
		cfg(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1) ^ 32'h0002_0000);
		send(lp, 32'h0);
		for (int c = 0; c < 7; c++) begin
			bus_u.cyc();
			tx((c % 3 != 2) ? 2'h0 : exp_kind(1'b1, 1'b0, c == 2), lp);
		end
		$display("repetition done");
		for (int m = 0; m < 6; m++) begin
			cfg(ctl(1'b0, 1'b0, 1'b0, m[2:1], 2'h0, m[0], 1'b0, 1'b1));
			wr(ttfs_pkg::OFS_RX_ACK, 32'h1);
			bus_u.rx(1'b1, {rnd(), rnd()});
			rd(ttfs_pkg::OFS_STATUS);
			chk(rdat[3:2], (m >= 4 && m[0]) ? 2'h3 : 2'h0);
			q = {rnd(), rnd()};
			bus_u.rx(1'b0, q);
			rd(ttfs_pkg::OFS_STATUS);
			chk(rdat[3:2], 2'h1);
			rd(ttfs_pkg::OFS_RX_DATA0);
			chk(rdat, q[31:0]);
			rd(ttfs_pkg::OFS_RX_DATA1);
			chk(rdat, q[63:32]);
		end
		$display("receive modes done");
		cfg(ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1));
		wr(ttfs_pkg::OFS_PDU_CFG0, 32'h0100_0108);
		wr(ttfs_pkg::OFS_PDU_CFG1, 32'h0101_0218);
		wr(ttfs_pkg::OFS_RX_ACK, 32'h301);
		p = {rnd(), rnd()} & ~64'h1 | 64'h2;
		bus_u.rx(1'b0, p);
		rd(ttfs_pkg::OFS_RX_DATA0);
		chk(rdat[15:8], q[15:8]);
		chk(rdat[31:24], p[31:24]);
		rd(ttfs_pkg::OFS_RX_DATA1);
		chk(rdat[7:0], p[39:32]);
		rd(ttfs_pkg::OFS_STATUS);
		chk(rdat[9:8], 2'h2);
		send(p, 32'h100);
		bus_u.cyc();
		tx(2'h1, {p[63:2], 2'h1});
		bus_u.cyc();
		tx(2'h1, {p[63:2], 2'h0});
		cfg(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1));
		send(p, 32'h0);
		bus_u.cyc();
		tx(2'h2, 64'h0);
		send(p, 32'h200);
		bus_u.cyc();
		tx(2'h1, {p[63:2], 2'h2});
		cfg(ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0));
		rd(ttfs_pkg::OFS_STATUS);
		chk(rdat[0], 1'b1);
		$display("pdu done");
		finish_test();
	end
endmodule
